// *** adcsq_pkg.sv ***
// constants, field layout and sequencer states for the adc mode and sequencer control block
// assumes a 40 MHz system clock and a 32-bit apb register bus
package adcsq_pkg;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STAT = 12'h004;
	localparam logic [11:0] OFS_CONV = 12'h008;
	localparam logic [11:0] OFS_RESULT = 12'h00C;
	localparam logic [11:0] OFS_SEQ_CTRL = 12'h010;
	localparam logic [11:0] OFS_SEQ_STAT = 12'h014;
	localparam logic [11:0] OFS_SEQ_TIMER = 12'h018;
	localparam logic [11:0] OFS_IRQ_EN = 12'h01C;
	localparam logic [3:0] PAGE_IRAM = 4'h1;
	localparam logic [3:0] PAGE_DRAM = 4'h2;
	localparam int CTL_DIFF = 5;
	localparam int CTL_GAIN = 6;
	localparam int CTL_AUTO = 8;
	localparam int CTL_PIPE = 9;
	localparam logic [9:0] CTRL_RST = 10'h000;
	localparam int INS_GAIN = 0;
	localparam int INS_DIFF = 2;
	localparam int INS_EN = 3;
	localparam int SQS_AVAIL = 0;
	localparam int SQS_OVF = 1;
	localparam int SQS_TERR = 2;
	localparam int SQS_RERR = 3;
	localparam logic [15:0] TIMER_RST = 16'h0000;
	localparam logic [15:0] TIMER_CONT = 16'h0000;
	localparam logic [5:0] IRQ_EN_RST = 6'h00;
	localparam int CLK_PS = 25000;
	localparam int SETTLE_NS = 10000;
	localparam int CONV_NS = 12500;
	localparam int TICK_NS = 100000;
	localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CONV_CYC = (CONV_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int TICK_CYC = (TICK_NS * 1000) / CLK_PS;
	typedef enum logic [2:0] {
		SQ_IDLE, SQ_FETCH, SQ_EVAL, SQ_SETTLE, SQ_CONV, SQ_END, SQ_WAIT
	} adcsq_state_t;
endpackage : adcsq_pkg

// *** adcsq_ram.sv ***
// simple dual-port memory with registered read data
// assumes one clock; no reset on the array
`timescale 1ns/1ps
module adcsq_ram #(
	parameter int W = 16,
	parameter int D = 32,
	parameter int AW = 5
) (
	// clock
	input wire logic clk,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [W-1:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [D];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule : adcsq_ram

// *** adcsq_tick.sv ***
// divider giving a one-cycle enable every DIV clocks while enabled
// assumes a synchronous active-high reset
`timescale 1ns/1ps
module adcsq_tick #(
	parameter int DIV = 4000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control and enable pulse
	input wire logic en,
	output logic tick
);
	localparam int CW = $clog2(DIV);
	logic [CW-1:0] cnt_ff;
	wire last = cnt_ff == CW'(DIV - 1);
	always_ff @(posedge clk) begin
		if (rst || !en || last) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end
	assign tick = en && last;
endmodule : adcsq_tick

// *** adcsq_top.sv ***
// conventional adc modes and channel sequencer behind an apb slave
// assumes the converter samples ADC_DATA valid when the conversion time ends
`timescale 1ns/1ps
module adcsq_top (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// analog front end
	output logic [4:0] MUX_CH,
	output logic MUX_DIFF,
	output logic [1:0] PGA_GAIN,
	output logic ADC_START,
	input wire logic [15:0] ADC_DATA,
	// interrupt request
	output logic IRQ_REQ
);
	localparam int SET_CYC = adcsq_pkg::SETTLE_CYC;
	localparam int CNV_CYC = adcsq_pkg::CONV_CYC;

	function automatic logic w1c(input logic flag, input logic clr, input logic set);
		w1c = set || (flag && !clr);
	endfunction : w1c

	// apb decode; every access answers with no wait state
	wire acc = PSEL && PENABLE;
	wire wr = acc && PWRITE;
	wire [4:0] pidx = PADDR[6:2];
	wire iram_sel = PADDR[11:8] == adcsq_pkg::PAGE_IRAM && PADDR[7] == 1'b0;
	wire dram_sel = PADDR[11:8] == adcsq_pkg::PAGE_DRAM && PADDR[7] == 1'b0;
	wire a_ctrl = PADDR == adcsq_pkg::OFS_CTRL;
	wire a_stat = PADDR == adcsq_pkg::OFS_STAT;
	wire a_conv = PADDR == adcsq_pkg::OFS_CONV;
	wire a_res = PADDR == adcsq_pkg::OFS_RESULT;
	wire a_sctl = PADDR == adcsq_pkg::OFS_SEQ_CTRL;
	wire a_sst = PADDR == adcsq_pkg::OFS_SEQ_STAT;
	wire a_tmr = PADDR == adcsq_pkg::OFS_SEQ_TIMER;
	wire a_ien = PADDR == adcsq_pkg::OFS_IRQ_EN;
	wire mapped = a_ctrl || a_stat || a_conv || a_res || a_sctl || a_sst || a_tmr || a_ien
		|| iram_sel || dram_sel;
	wire apb_iram_rd = PSEL && !PWRITE && iram_sel;
	wire wr_ctrl = wr && a_ctrl;
	wire wr_conv = wr && a_conv;
	wire wr_sst = wr && a_sst;
	assign PREADY = 1'b1;
	assign PSLVERR = acc && !mapped;

	// registers
	logic [9:0] ctrl_ff;
	logic [15:0] timer_ff;
	logic [5:0] irq_en_ff;
	logic [15:0] result_ff;
	logic [15:0] prev_ff;
	logic [3:0] sst_ff;
	logic seq_run_ff;
	logic [8:0] settle_cnt_ff;
	logic [8:0] conv_cnt_ff;
	logic conv_seq_ff;
	logic auto_pend_ff;
	logic adc_start_ff;
	logic irq_ff;
	logic [4:0] mux_ch_ff;
	logic mux_diff_ff;
	logic [1:0] gain_ff;
	adcsq_pkg::adcsq_state_t state_ff;
	adcsq_pkg::adcsq_state_t nxt_state;
	logic [4:0] idx_ff;
	logic any_en_ff;
	logic bank_ff;
	logic [15:0] tcnt_ff;

	wire auto_mode = ctrl_ff[adcsq_pkg::CTL_AUTO];
	wire pipe_mode = ctrl_ff[adcsq_pkg::CTL_PIPE];
	wire cont_mode = timer_ff == adcsq_pkg::TIMER_CONT;
	wire seq_act = state_ff != adcsq_pkg::SQ_IDLE;
	wire settle_busy = settle_cnt_ff != 9'h000;
	wire conv_busy = conv_cnt_ff != 9'h000;
	wire settle_done = settle_cnt_ff == 9'h001;
	wire conv_end = conv_cnt_ff == 9'h001;

	// instruction and data memories
	wire [3:0] iram_q;
	wire [15:0] dram_q;
	wire ins_en = iram_q[adcsq_pkg::INS_EN];
	wire [4:0] iram_raddr = apb_iram_rd ? pidx : idx_ff;
	wire dram_we = conv_end && conv_seq_ff;
	adcsq_ram #(.W(4), .D(32), .AW(5)) u_iram (
		.clk(SYS_CLK),
		.we(wr && iram_sel),
		.waddr(pidx),
		.wdata(PWDATA[3:0]),
		.raddr(iram_raddr),
		.rdata(iram_q)
	);
	// sequence results go to the hidden bank and become visible at the end of a pass without overflow
	adcsq_ram #(.W(16), .D(64), .AW(6)) u_dram (
		.clk(SYS_CLK),
		.we(dram_we),
		.waddr({~bank_ff, idx_ff}),
		.wdata(ADC_DATA),
		.raddr({bank_ff, pidx}),
		.rdata(dram_q)
	);

	// 100us timebase for the sequencer timer
	wire tick;
	adcsq_tick #(.DIV(adcsq_pkg::TICK_CYC)) u_tick (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.en(seq_act && !cont_mode),
		.tick(tick)
	);

	// conversion triggers
	wire norm_start = wr_conv && !auto_mode && !seq_act && !conv_busy;
	wire auto_req = (settle_done || auto_pend_ff) && auto_mode && !seq_act;
	wire auto_start = auto_req && !conv_busy;
	wire seq_cstart = state_ff == adcsq_pkg::SQ_SETTLE && !settle_busy && !conv_busy;
	wire conv_start = norm_start || auto_start || seq_cstart;
	wire seq_eval_en = state_ff == adcsq_pkg::SQ_EVAL && ins_en;
	wire ctrl_apply = wr_ctrl && !seq_act;
	wire settle_start = ctrl_apply || seq_eval_en;

	// sequencer timer and end-of-pass decisions
	wire t_hit = tick && (tcnt_ff + 16'h0001 == timer_ff);
	wire t_err = t_hit && state_ff != adcsq_pkg::SQ_WAIT;
	wire at_end = state_ff == adcsq_pkg::SQ_END;
	wire r_err = at_end && !any_en_ff;
	wire o_err = at_end && any_en_ff && !cont_mode && sst_ff[adcsq_pkg::SQS_AVAIL];
	wire done_ok = at_end && any_en_ff && !o_err;
	wire seq_go = wr && a_sctl && PWDATA[0] && !seq_act;
	wire last_ch = idx_ff == 5'h1F;
	wire step = (state_ff == adcsq_pkg::SQ_EVAL && !ins_en)
		|| (state_ff == adcsq_pkg::SQ_CONV && conv_end);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			adcsq_pkg::SQ_IDLE: begin
				if (seq_go) begin
					nxt_state = adcsq_pkg::SQ_FETCH;
				end
			end
			adcsq_pkg::SQ_FETCH: begin
				if (!apb_iram_rd) begin
					nxt_state = adcsq_pkg::SQ_EVAL;
				end
			end
			adcsq_pkg::SQ_EVAL: begin
				if (ins_en) begin
					nxt_state = adcsq_pkg::SQ_SETTLE;
				end else begin
					nxt_state = last_ch ? adcsq_pkg::SQ_END : adcsq_pkg::SQ_FETCH;
				end
			end
			adcsq_pkg::SQ_SETTLE: begin
				if (seq_cstart) begin
					nxt_state = adcsq_pkg::SQ_CONV;
				end
			end
			adcsq_pkg::SQ_CONV: begin
				if (conv_end) begin
					nxt_state = last_ch ? adcsq_pkg::SQ_END : adcsq_pkg::SQ_FETCH;
				end
			end
			adcsq_pkg::SQ_END: begin
				if (r_err || o_err || !seq_run_ff) begin
					nxt_state = adcsq_pkg::SQ_IDLE;
				end else if (cont_mode) begin
					nxt_state = adcsq_pkg::SQ_FETCH;
				end else begin
					nxt_state = adcsq_pkg::SQ_WAIT;
				end
			end
			adcsq_pkg::SQ_WAIT: begin
				if (!seq_run_ff) begin
					nxt_state = adcsq_pkg::SQ_IDLE;
				end else if (t_hit) begin
					nxt_state = adcsq_pkg::SQ_FETCH;
				end
			end
			default: begin
				nxt_state = adcsq_pkg::SQ_IDLE;
			end
		endcase
	end

	// sequencer state, channel index and timer
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			state_ff <= adcsq_pkg::SQ_IDLE;
			idx_ff <= 5'h00;
			any_en_ff <= 1'b0;
			bank_ff <= 1'b0;
			tcnt_ff <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			if (seq_go || (at_end && nxt_state == adcsq_pkg::SQ_FETCH)) begin
				idx_ff <= 5'h00;
				any_en_ff <= 1'b0;
			end else if (step && !last_ch) begin
				idx_ff <= idx_ff + 5'h01;
			end else if (state_ff == adcsq_pkg::SQ_WAIT && t_hit) begin
				idx_ff <= 5'h00;
				any_en_ff <= 1'b0;
			end
			if (seq_eval_en) begin
				any_en_ff <= 1'b1;
			end
			if (done_ok) begin
				bank_ff <= ~bank_ff;
			end
			if (seq_go || t_hit) begin
				tcnt_ff <= 16'h0000;
			end else if (tick) begin
				tcnt_ff <= tcnt_ff + 16'h0001;
			end
		end
	end

	// run bit, status flags; a set in the clearing cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			seq_run_ff <= 1'b0;
			sst_ff <= 4'h0;
		end else begin
			if (seq_go) begin
				seq_run_ff <= 1'b1;
			end else if ((wr && a_sctl && !PWDATA[0]) || t_err || r_err || o_err) begin
				seq_run_ff <= 1'b0;
			end
			sst_ff[adcsq_pkg::SQS_AVAIL] <= w1c(sst_ff[adcsq_pkg::SQS_AVAIL],
				wr_sst && PWDATA[adcsq_pkg::SQS_AVAIL], done_ok);
			sst_ff[adcsq_pkg::SQS_OVF] <= w1c(sst_ff[adcsq_pkg::SQS_OVF],
				wr_sst && PWDATA[adcsq_pkg::SQS_OVF], o_err);
			sst_ff[adcsq_pkg::SQS_TERR] <= w1c(sst_ff[adcsq_pkg::SQS_TERR],
				wr_sst && PWDATA[adcsq_pkg::SQS_TERR], t_err);
			sst_ff[adcsq_pkg::SQS_RERR] <= w1c(sst_ff[adcsq_pkg::SQS_RERR],
				wr_sst && PWDATA[adcsq_pkg::SQS_RERR], r_err);
		end
	end

	// software registers and analog path selection
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			ctrl_ff <= adcsq_pkg::CTRL_RST;
			timer_ff <= adcsq_pkg::TIMER_RST;
			irq_en_ff <= adcsq_pkg::IRQ_EN_RST;
			mux_ch_ff <= 5'h00;
			mux_diff_ff <= 1'b0;
			gain_ff <= 2'h0;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= PWDATA[9:0];
			end
			if (wr && a_tmr) begin
				timer_ff <= PWDATA[15:0];
			end
			if (wr && a_ien) begin
				irq_en_ff <= PWDATA[5:0];
			end
			if (ctrl_apply) begin
				mux_ch_ff <= PWDATA[4:0];
				mux_diff_ff <= PWDATA[adcsq_pkg::CTL_DIFF];
				gain_ff <= PWDATA[adcsq_pkg::CTL_GAIN+:2];
			end else if (seq_eval_en) begin
				mux_ch_ff <= idx_ff;
				mux_diff_ff <= iram_q[adcsq_pkg::INS_DIFF];
				gain_ff <= iram_q[adcsq_pkg::INS_GAIN+:2];
			end
		end
	end

	// settling and conversion timers, result path
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			settle_cnt_ff <= 9'h000;
			conv_cnt_ff <= 9'h000;
			conv_seq_ff <= 1'b0;
			auto_pend_ff <= 1'b0;
			adc_start_ff <= 1'b0;
			result_ff <= 16'h0000;
			prev_ff <= 16'h0000;
		end else begin
			if (settle_start) begin
				settle_cnt_ff <= 9'(SET_CYC);
			end else if (settle_busy) begin
				settle_cnt_ff <= settle_cnt_ff - 9'h001;
			end
			if (conv_start) begin
				conv_cnt_ff <= 9'(CNV_CYC);
				conv_seq_ff <= seq_cstart;
			end else if (conv_busy) begin
				conv_cnt_ff <= conv_cnt_ff - 9'h001;
			end
			auto_pend_ff <= auto_req && conv_busy && !ctrl_apply;
			adc_start_ff <= conv_start;
			if (conv_end && !conv_seq_ff) begin
				prev_ff <= ADC_DATA;
				result_ff <= pipe_mode ? prev_ff : ADC_DATA;
			end
		end
	end

	// one-cycle interrupt request from enabled events
	wire [5:0] ev = {r_err, t_err, o_err, done_ok, conv_end && !conv_seq_ff,
		settle_done && !auto_mode && !seq_act};
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(ev & irq_en_ff);
		end
	end

	// read mux; overflow reads zero in continuous mode
	wire [3:0] sst_rd = {sst_ff[3:2], sst_ff[adcsq_pkg::SQS_OVF] && !cont_mode, sst_ff[0]};
	always_comb begin
		PRDATA = 32'h0000_0000;
		if (acc && !PWRITE) begin
			if (a_ctrl) PRDATA = {22'h000000, ctrl_ff};
			else if (a_stat) PRDATA = {30'h00000000, conv_busy, settle_busy};
			else if (a_res) PRDATA = {16'h0000, result_ff};
			else if (a_sctl) PRDATA = {30'h00000000, seq_act, seq_run_ff};
			else if (a_sst) PRDATA = {28'h0000000, sst_rd};
			else if (a_tmr) PRDATA = {16'h0000, timer_ff};
			else if (a_ien) PRDATA = {26'h0000000, irq_en_ff};
			else if (iram_sel) PRDATA = {28'h0000000, iram_q};
			else if (dram_sel) PRDATA = {16'h0000, dram_q};
		end
	end

	assign MUX_CH = mux_ch_ff;
	assign MUX_DIFF = mux_diff_ff;
	assign PGA_GAIN = gain_ff;
	assign ADC_START = adc_start_ff;
	assign IRQ_REQ = irq_ff;

	a_settle_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		settle_start |=> settle_busy [*8])
		else $error("settling busy not raised after control write");
	a_conv_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		ADC_START |-> conv_busy ##1 conv_busy)
		else $error("conversion busy not held after start");
	a_norm_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(wr_conv && !auto_mode && !seq_act && !conv_busy) |=> ADC_START)
		else $error("convert write did not start a conversion");
	a_auto_start: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(settle_done && auto_mode && !seq_act && !conv_busy && !ctrl_apply) |=> ADC_START)
		else $error("automatic mode did not start after settling");
	a_pipe_result: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(conv_end && !conv_seq_ff && pipe_mode) |=> result_ff == $past(prev_ff))
		else $error("pipeline did not deliver previous result");
	a_nopipe_result: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(conv_end && !conv_seq_ff && !pipe_mode) |=> result_ff == $past(ADC_DATA))
		else $error("result register missed current conversion");
	a_avail_set: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		done_ok |=> sst_ff[0] && bank_ff != $past(bank_ff))
		else $error("data available not set at sequence end");
	a_ram_err: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		r_err |=> sst_ff[3] && !seq_run_ff && state_ff == adcsq_pkg::SQ_IDLE)
		else $error("empty sequence did not flag and halt");
	a_ovf_cont: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		(acc && !PWRITE && a_sst && cont_mode) |-> !PRDATA[adcsq_pkg::SQS_OVF])
		else $error("overflow visible in continuous mode");
	a_conv_len: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
		ADC_START |-> ##[1:600] !conv_busy)
		else $error("conversion did not finish in time");
endmodule : adcsq_top

// *** adcsq_afe.sv ***
// behavioural analog front end: multiplexer, gain stage and converter
// assumes a one-cycle start pulse and sampling within the conversion time
`timescale 1ns/1ps
module adcsq_afe (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// path selection and start
	input wire logic [4:0] mux_ch,
	input wire logic mux_diff,
	input wire logic [1:0] pga_gain,
	input wire logic adc_start,
	// converter result
	output logic [15:0] adc_data
);
	int left;
	// result encodes the path settings seen at the start pulse
	always @(posedge clk) begin
		if (rst) begin
			left <= 0;
			adc_data <= 16'hFFFF;
		end else if (adc_start) begin
			left <= adcsq_pkg::CONV_CYC + 1;
			adc_data <= {4'hC, 1'b0, pga_gain, mux_diff, 3'h0, mux_ch};
		end else if (left > 0) begin
			left <= left - 1;
		end else begin
			// outside a conversion the output is not valid
			adc_data <= ~adc_data;
		end
	end
endmodule : adcsq_afe

// *** adcsq_top_tb.sv ***
// self-checking bench: apb master tasks, front end model, mode and sequencer tests
// assumes zero or more apb wait states and the offsets of the package
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adcsq_top_tb;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, mux_diff, adc_start, irq, err;
	logic [4:0] mux_ch;
	logic [1:0] pga_gain;
	logic [15:0] adc_data;
	logic [4:0] starts[$];
	int n_mismatch = 0, check_count = 0, irq_n = 0, base;

	adcsq_top adcsq_top_i (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .MUX_CH(mux_ch), .MUX_DIFF(mux_diff), .PGA_GAIN(pga_gain),
		.ADC_START(adc_start), .ADC_DATA(adc_data), .IRQ_REQ(irq));
	adcsq_afe adcsq_afe_i (.clk(clk), .rst(rst), .mux_ch(mux_ch), .mux_diff(mux_diff),
		.pga_gain(pga_gain), .adc_start(adc_start), .adc_data(adc_data));

	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (irq === 1'b1) irq_n <= irq_n + 1;
		if (adc_start === 1'b1) starts.push_back(mux_ch);
	end

	function automatic logic [31:0] ev(logic [4:0] ch, logic d, logic [1:0] g);
		return {16'h0, 4'hC, 1'b0, g, d, 3'h0, ch};
	endfunction : ev
	function automatic logic [31:0] cw(logic [4:0] ch, logic d, logic [1:0] g, logic au, logic pp);
		return {22'h0, pp, au, g, d, ch};
	endfunction : cw

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rdc
	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd & m) !== v && n < 4000);
		`CHK(rd & m, v)
	endtask : poll
	task automatic irqc(input int e);
		repeat (2) @(posedge clk);
		`CHK(irq_n, e)
	endtask : irqc
	task automatic auto_run(input logic [31:0] c, input logic [31:0] e);
		wr(adcsq_pkg::OFS_CTRL, c);
		poll(adcsq_pkg::OFS_STAT, 32'h2, 32'h2);
		poll(adcsq_pkg::OFS_STAT, 32'h3, 32'h0);
		rdc(adcsq_pkg::OFS_RESULT, e);
	endtask : auto_run
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(adcsq_pkg::OFS_CTRL, 32'h0);
		rdc(adcsq_pkg::OFS_SEQ_TIMER, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		`CHK(err, 1'b1)
		wr(adcsq_pkg::OFS_IRQ_EN, 32'h3F);
		// normal mode, no pipeline, then a repeat on the same path
		wr(adcsq_pkg::OFS_CTRL, cw(5'h03, 1'b1, 2'h2, 1'b0, 1'b0));
		rdc(adcsq_pkg::OFS_STAT, 32'h1);
		`CHK({mux_ch, mux_diff, pga_gain}, {5'h03, 1'b1, 2'h2})
		poll(adcsq_pkg::OFS_STAT, 32'h1, 32'h0);
		wr(adcsq_pkg::OFS_CONV, 32'h0);
		rdc(adcsq_pkg::OFS_STAT, 32'h2);
		poll(adcsq_pkg::OFS_STAT, 32'h2, 32'h0);
		rdc(adcsq_pkg::OFS_RESULT, ev(5'h03, 1'b1, 2'h2));
		wr(adcsq_pkg::OFS_CONV, 32'h0);
		poll(adcsq_pkg::OFS_STAT, 32'h2, 32'h0);
		`CHK(starts.size(), 2)
		irqc(3);
		// pipeline, next path settles while converting
		wr(adcsq_pkg::OFS_CTRL, cw(5'h05, 1'b0, 2'h1, 1'b0, 1'b1));
		poll(adcsq_pkg::OFS_STAT, 32'h1, 32'h0);
		wr(adcsq_pkg::OFS_CONV, 32'h0);
		wr(adcsq_pkg::OFS_CTRL, cw(5'h07, 1'b0, 2'h3, 1'b0, 1'b1));
		rdc(adcsq_pkg::OFS_STAT, 32'h3);
		poll(adcsq_pkg::OFS_STAT, 32'h3, 32'h0);
		wr(adcsq_pkg::OFS_CONV, 32'h0);
		poll(adcsq_pkg::OFS_STAT, 32'h2, 32'h0);
		rdc(adcsq_pkg::OFS_RESULT, ev(5'h05, 1'b0, 2'h1));
		irqc(7);
		auto_run(cw(5'h0A, 1'b0, 2'h0, 1'b1, 1'b1), ev(5'h07, 1'b0, 2'h3));
		auto_run(cw(5'h0B, 1'b0, 2'h2, 1'b1, 1'b1), ev(5'h0A, 1'b0, 2'h0));
		auto_run(cw(5'h09, 1'b1, 2'h1, 1'b1, 1'b0), ev(5'h09, 1'b1, 2'h1));
		irqc(10);
		wr(adcsq_pkg::OFS_CTRL, 32'h0);
		// sequencer, continuous mode, channels 1 and 4
		for (int i = 0; i < 32; i++) begin
			wr(12'h100 + 12'(4 * i), (i == 1) ? 32'hA : (i == 4) ? 32'hD : 32'h0);
		end
		repeat (900) @(posedge clk);
		starts.delete();
		base = irq_n;
		wr(adcsq_pkg::OFS_SEQ_CTRL, 32'h1);
		poll(adcsq_pkg::OFS_SEQ_STAT, 32'h1, 32'h1);
		irqc(base + 1);
		`CHK(starts[0], 5'h01)
		`CHK(starts[1], 5'h04)
		rdc(12'h204, ev(5'h01, 1'b0, 2'h2));
		rdc(12'h210, ev(5'h04, 1'b1, 2'h1));
		for (int n = 0; n < 12000 && starts.size() < 6; n++) @(posedge clk);
		`CHK(starts.size() > 5, 1'b1)
		rdc(adcsq_pkg::OFS_SEQ_STAT, 32'h1);
		wr(adcsq_pkg::OFS_SEQ_CTRL, 32'h0);
		poll(adcsq_pkg::OFS_SEQ_CTRL, 32'h2, 32'h0);
		wr(adcsq_pkg::OFS_SEQ_STAT, 32'h1);
		rdc(adcsq_pkg::OFS_SEQ_STAT, 32'h0);
		// no channel enabled
		wr(12'h104, 32'h0);
		wr(12'h110, 32'h0);
		wr(adcsq_pkg::OFS_SEQ_CTRL, 32'h1);
		poll(adcsq_pkg::OFS_SEQ_STAT, 32'h8, 32'h8);
		poll(adcsq_pkg::OFS_SEQ_CTRL, 32'h2, 32'h0);
		wr(adcsq_pkg::OFS_SEQ_STAT, 32'h8);
		rdc(adcsq_pkg::OFS_SEQ_STAT, 32'h0);
		// timer mode, data never acknowledged
		wr(12'h104, 32'hA);
		wr(adcsq_pkg::OFS_SEQ_TIMER, 32'h1);
		starts.delete();
		wr(adcsq_pkg::OFS_SEQ_CTRL, 32'h1);
		poll(adcsq_pkg::OFS_SEQ_STAT, 32'h2, 32'h2);
		poll(adcsq_pkg::OFS_SEQ_CTRL, 32'h2, 32'h0);
		`CHK(starts.size(), 2)
		// overflow stays set but is hidden while continuous mode is selected
		wr(adcsq_pkg::OFS_SEQ_TIMER, 32'h0);
		rdc(adcsq_pkg::OFS_SEQ_STAT, 32'h1);
		wr(adcsq_pkg::OFS_SEQ_TIMER, 32'h1);
		rdc(adcsq_pkg::OFS_SEQ_STAT, 32'h3);
		wr(adcsq_pkg::OFS_SEQ_STAT, 32'hF);
		// period shorter than a six channel pass
		for (int i = 0; i < 6; i++) wr(12'h100 + 12'(4 * i), 32'hA);
		wr(adcsq_pkg::OFS_SEQ_CTRL, 32'h1);
		poll(adcsq_pkg::OFS_SEQ_STAT, 32'h4, 32'h4);
		poll(adcsq_pkg::OFS_SEQ_CTRL, 32'h2, 32'h0);
		end_sim;
	end
endmodule : adcsq_top_tb
